/* File: core/pcst_ctrl.sv */
// pcst_ctrl: idle-state entry/exit sequencer and stop-clock throttle engine with apb registers.
// assumes break-event inputs and stop_grant come from logic on pclk; the two pins are async.
//
// What this block does
// - level-2 register read asserts stop-clock and enters C2.
// - level-3 read with deepest-on-level3 clear enters C3.
// - level-4 read, or level-3 read with deepest-on-level3 set, enters C4.
// - unmasked interrupt, NMI, SMI or init event returns C2/C3/C4 to C0.
// - bus master request breaks C3/C4, not C2, only with bus-master reload set.
// - stop-clock assertion latches float-error pin level for the error state machine.
// - after stop-grant, low pending-break pin with mux enabled forces C0.
// - float-error pin used as error again 180 ns after release, within 2 clocks.
// - pending-break wake sets no status bit.
// - manual throttling pulses stop-clock at throttle duty while throttle enable set.
// - thermal alarm over 2 s forces throttling at thermal duty until alarm ends.
// - thermal override duty wins over software throttle duty.
// - no throttling while in C2, C3 or C4.
// - sleep enable disables both software and thermal throttling.
// - level read during throttling enters matching C state until break.
// - throttling resumes after break; first assertion may lag one 1024-clock period.
// - stop-clock during C1 reports C2 after stop-grant, C1 after release.
// - processor sleep asserts before stop-processor-clock.
// - deep-idle status flags entering or just leaving C3/C4.
// - regulator low voltage asserted during C4.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module pcst_ctrl #(
  parameter int unsigned THERMAL_OVERRIDE_CYCLES = pcst_pkg::THERMAL_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // break events and processor status from on-chip logic
  input  wire logic        unmasked_irq,
  input  wire logic        nmi_event,
  input  wire logic        smi_event,
  input  wire logic        init_event,
  input  wire logic        bus_master_req,
  input  wire logic        stop_grant,
  input  wire logic        processor_in_c1,
  // asynchronous pins
  input  wire logic        float_error_pending_break_n,
  input  wire logic        thermal_alarm_n,
  // clock control outputs
  output logic             stop_clock_request_n,
  output logic             stop_processor_clock_n,
  output logic             processor_sleep_n,
  output logic             deeper_sleep_n,
  output logic             deep_idle_status_n,
  output logic             regulator_low_voltage,
  output logic             float_error_to_fsm_n
);

  // pin synchronisers: bit 0 float error, bit 1 thermal alarm
  logic [1:0] pin_raw;
  logic [1:0] pin_s1_ff;
  logic [1:0] pin_s2_ff;
  logic [1:0] pin_s3_ff;
  logic [1:0] pin_ff;
  assign pin_raw = {thermal_alarm_n, float_error_pending_break_n};

  // three flops, level accepted once stages two and three agree
  for (genvar gi = 0; gi < 2; gi++)
  begin : g_sync
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        pin_s1_ff[gi] <= 1'b1;
        pin_s2_ff[gi] <= 1'b1;
        pin_s3_ff[gi] <= 1'b1;
        pin_ff[gi]    <= 1'b1;
      end
      else
      begin
        pin_s1_ff[gi] <= pin_raw[gi];
        pin_s2_ff[gi] <= pin_s1_ff[gi];
        pin_s3_ff[gi] <= pin_s2_ff[gi];
        if (pin_s2_ff[gi] == pin_s3_ff[gi])
          pin_ff[gi] <= pin_s3_ff[gi];
      end
    end
  end

  logic float_error_pending_break_n_n;
  logic thermal_active;
  assign float_error_pending_break_n_n         = pin_ff[0];
  assign thermal_active = ~pin_ff[1];

  // state registers
  logic [31:0]                          prdata_ff, nxt_prdata;
  logic                                 pready_ff, nxt_pready;
  logic                                 pslverr_ff, nxt_pslverr;
  logic [pcst_pkg::CTRL_WIDTH-1:0]      ctrl_ff, nxt_ctrl;
  pcst_pkg::pcst_state_t                state_ff, nxt_state;
  pcst_pkg::pcst_target_t               target_ff, nxt_target;
  logic                                 grant_seen_ff, nxt_grant_seen;
  logic                                 stop_n_ff, nxt_stop_n;
  logic                                 cpu_stop_n_ff, nxt_cpu_stop_n;
  logic                                 sleep_n_ff, nxt_sleep_n;
  logic                                 deeper_n_ff, nxt_deeper_n;
  logic                                 idle_stat_n_ff, nxt_idle_stat_n;
  logic                                 reg_low_ff, nxt_reg_low;
  logic                                 float_error_pending_break_n_latch_ff, nxt_float_error_pending_break_n_latch;
  logic [1:0]                           hold_ff, nxt_hold;
  logic                                 use_pin_ff, nxt_use_pin;
  logic                                 float_error_pending_break_n_fsm_n_ff, nxt_float_error_pending_break_n_fsm_n;
  logic [pcst_pkg::THERMAL_CNT_WIDTH-1:0]  therm_cnt_ff, nxt_therm_cnt;
  logic                                    override_ff, nxt_override;
  logic [pcst_pkg::THROTTLE_CNT_WIDTH-1:0] period_ff, nxt_period;
  logic                                    thr_stop_ff, nxt_thr_stop;

  // control fields
  logic [pcst_pkg::DUTY_WIDTH-1:0] throttle_duty;
  logic [pcst_pkg::DUTY_WIDTH-1:0] thermal_override_duty;
  logic [pcst_pkg::DUTY_WIDTH-1:0] duty_sel;
  logic                            throttle_enable;
  logic                            bus_master_reload;
  logic                            deepest_on_level3_enable;
  logic                            pending_break_mux;
  logic                            sleep_enable;
  assign throttle_duty            = ctrl_ff[pcst_pkg::CTRL_THROTTLE_DUTY_LSB +: 3];
  assign thermal_override_duty    = ctrl_ff[pcst_pkg::CTRL_THERMAL_DUTY_LSB +: 3];
  assign throttle_enable          = ctrl_ff[pcst_pkg::CTRL_THROTTLE_ENABLE];
  assign bus_master_reload        = ctrl_ff[pcst_pkg::CTRL_BUS_MASTER_RELOAD];
  assign deepest_on_level3_enable = ctrl_ff[pcst_pkg::CTRL_DEEPEST_ON_LEVEL3];
  assign pending_break_mux        = ctrl_ff[pcst_pkg::CTRL_PENDING_BREAK_MUX];
  assign sleep_enable             = ctrl_ff[pcst_pkg::CTRL_SLEEP_ENABLE];

  // reported c-state, read back through status
  logic [2:0] cstate_code;
  always_comb
  begin
    cstate_code = pcst_pkg::CSTATE_C0;
    if (state_ff == pcst_pkg::ST_C0)
    begin
      if (processor_in_c1)
        cstate_code = (grant_seen_ff && !stop_n_ff) ? pcst_pkg::CSTATE_C2 : pcst_pkg::CSTATE_C1;
    end
    else if (target_ff == pcst_pkg::TGT_C2)
      cstate_code = pcst_pkg::CSTATE_C2;
    else if (target_ff == pcst_pkg::TGT_C3)
      cstate_code = pcst_pkg::CSTATE_C3;
    else
      cstate_code = pcst_pkg::CSTATE_C4;
  end

  // apb slave: one wait state, level registers are read-only triggers
  logic                   level_read;
  pcst_pkg::pcst_target_t level_target;
  logic                   access_done;
  always_comb
  begin
    access_done  = psel && penable && !pready_ff;
    nxt_pready   = access_done;
    nxt_pslverr  = 1'b0;
    nxt_prdata   = 32'h0000_0000;
    nxt_ctrl     = ctrl_ff;
    level_read   = 1'b0;
    level_target = pcst_pkg::TGT_C2;
    if (access_done)
    begin
      if (paddr == pcst_pkg::ADDR_CTRL)
      begin
        if (pwrite)
          nxt_ctrl = pwdata[pcst_pkg::CTRL_WIDTH-1:0];
        nxt_prdata[pcst_pkg::CTRL_WIDTH-1:0] = ctrl_ff;
      end
      else if (paddr == pcst_pkg::ADDR_LEVEL2)
      begin
        level_read = !pwrite;
      end
      else if (paddr == pcst_pkg::ADDR_LEVEL3)
      begin
        level_read   = !pwrite;
        level_target = deepest_on_level3_enable ? pcst_pkg::TGT_C4 : pcst_pkg::TGT_C3;
      end
      else if (paddr == pcst_pkg::ADDR_LEVEL4)
      begin
        level_read   = !pwrite;
        level_target = pcst_pkg::TGT_C4;
      end
      else if (paddr == pcst_pkg::ADDR_STATUS)
      begin
        nxt_prdata[pcst_pkg::STAT_CSTATE_LSB +: 3] = cstate_code;
        nxt_prdata[pcst_pkg::STAT_THROTTLING]      = thr_stop_ff;
        nxt_prdata[pcst_pkg::STAT_THERMAL_OV]      = override_ff;
        nxt_prdata[pcst_pkg::STAT_THERMAL_IN]      = thermal_active;
      end
      else
        nxt_pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      ctrl_ff    <= pcst_pkg::CTRL_RESET;
    end
    else
    begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
      ctrl_ff    <= nxt_ctrl;
    end
  end

  // thermal override timer and throttle period counter
  logic throttle_req;
  always_comb
  begin
    // alarm must outlast the full window
    nxt_therm_cnt = '0;
    if (thermal_active)
      nxt_therm_cnt = (therm_cnt_ff == pcst_pkg::THERMAL_CNT_WIDTH'(THERMAL_OVERRIDE_CYCLES))
                      ? therm_cnt_ff : therm_cnt_ff + 1'b1;
    nxt_override = thermal_active &&
                   (therm_cnt_ff == pcst_pkg::THERMAL_CNT_WIDTH'(THERMAL_OVERRIDE_CYCLES));
    nxt_period = period_ff + 1'b1;
    throttle_req = !sleep_enable && (override_ff || throttle_enable);
    duty_sel = override_ff ? thermal_override_duty : throttle_duty;
    // duty in eighths, only from c0
    nxt_thr_stop = throttle_req && (state_ff == pcst_pkg::ST_C0) &&
                   (period_ff[pcst_pkg::THROTTLE_CNT_WIDTH-1 -: 3] < duty_sel);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      therm_cnt_ff <= '0;
      override_ff  <= 1'b0;
      period_ff    <= '0;
      thr_stop_ff  <= 1'b0;
    end
    else
    begin
      therm_cnt_ff <= nxt_therm_cnt;
      override_ff  <= nxt_override;
      period_ff    <= nxt_period;
      thr_stop_ff  <= nxt_thr_stop;
    end
  end

  // idle sequencer: stop-clock, grant, sleep, deep, exit
  logic break_evt;
  logic pbe_break;
  always_comb
  begin
    pbe_break = grant_seen_ff && pending_break_mux && !float_error_pending_break_n_n && !stop_n_ff;
    // wake sources, bus master ignored for c2
    break_evt = unmasked_irq || nmi_event || smi_event || init_event || pbe_break ||
                (bus_master_req && bus_master_reload && (target_ff != pcst_pkg::TGT_C2));
    nxt_state  = state_ff;
    nxt_target = target_ff;
    case (state_ff)
      pcst_pkg::ST_C0:
      begin
        if (level_read)
        begin
          nxt_state  = pcst_pkg::ST_GRANT;
          nxt_target = level_target;
        end
      end
      pcst_pkg::ST_GRANT:
      begin
        if (break_evt)
          nxt_state = pcst_pkg::ST_EXIT;
        else if (grant_seen_ff && (target_ff != pcst_pkg::TGT_C2))
          nxt_state = pcst_pkg::ST_SLEEP;
      end
      pcst_pkg::ST_SLEEP:
      begin
        nxt_state = break_evt ? pcst_pkg::ST_EXIT : pcst_pkg::ST_DEEP;
      end
      pcst_pkg::ST_DEEP:
      begin
        if (break_evt)
          nxt_state = pcst_pkg::ST_EXIT;
      end
      default:
      begin
        nxt_state = pcst_pkg::ST_C0;
      end
    endcase
    // a fresh throttle stop waits until the released pin has been looked at
    // otherwise a break straight into a throttle window would hide a real float error
    nxt_stop_n = !(((nxt_state != pcst_pkg::ST_C0) && (nxt_state != pcst_pkg::ST_EXIT)) ||
                   ((nxt_state == pcst_pkg::ST_C0) && thr_stop_ff && (use_pin_ff || !stop_n_ff)));
    // sleep held across deep and exit
    nxt_sleep_n    = !((nxt_state == pcst_pkg::ST_SLEEP) || (nxt_state == pcst_pkg::ST_DEEP) ||
                       (nxt_state == pcst_pkg::ST_EXIT));
    nxt_cpu_stop_n = !(nxt_state == pcst_pkg::ST_DEEP);
    nxt_deeper_n   = !(nxt_state == pcst_pkg::ST_DEEP);
    nxt_reg_low    = (nxt_state == pcst_pkg::ST_DEEP) && (nxt_target == pcst_pkg::TGT_C4);
    nxt_idle_stat_n = !((nxt_state != pcst_pkg::ST_C0) && (nxt_target != pcst_pkg::TGT_C2));
    // grant counted only while stop-clock held
    nxt_grant_seen = !stop_n_ff && nxt_stop_n == 1'b0 && (grant_seen_ff || stop_grant);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff       <= pcst_pkg::ST_C0;
      target_ff      <= pcst_pkg::TGT_C2;
      grant_seen_ff  <= 1'b0;
      stop_n_ff      <= 1'b1;
      cpu_stop_n_ff  <= 1'b1;
      sleep_n_ff     <= 1'b1;
      deeper_n_ff    <= 1'b1;
      idle_stat_n_ff <= 1'b1;
      reg_low_ff     <= 1'b0;
    end
    else
    begin
      state_ff       <= nxt_state;
      target_ff      <= nxt_target;
      grant_seen_ff  <= nxt_grant_seen;
      stop_n_ff      <= nxt_stop_n;
      cpu_stop_n_ff  <= nxt_cpu_stop_n;
      sleep_n_ff     <= nxt_sleep_n;
      deeper_n_ff    <= nxt_deeper_n;
      idle_stat_n_ff <= nxt_idle_stat_n;
      reg_low_ff     <= nxt_reg_low;
    end
  end

  // float-error view for the error state machine
  always_comb
  begin
    nxt_float_error_pending_break_n_latch = (stop_n_ff && !nxt_stop_n) ? float_error_pending_break_n_n : float_error_pending_break_n_latch_ff;
    if (!nxt_stop_n)
      nxt_hold = 2'(pcst_pkg::PBE_HOLD_CYC);
    else
      nxt_hold = (hold_ff != 2'h0) ? hold_ff - 2'h1 : 2'h0;
    nxt_use_pin    = nxt_stop_n && (hold_ff == 2'h0);
    nxt_float_error_pending_break_n_fsm_n = use_pin_ff ? float_error_pending_break_n_n : float_error_pending_break_n_latch_ff;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      float_error_pending_break_n_latch_ff <= 1'b1;
      hold_ff       <= 2'h0;
      use_pin_ff    <= 1'b1;
      float_error_pending_break_n_fsm_n_ff <= 1'b1;
    end
    else
    begin
      float_error_pending_break_n_latch_ff <= nxt_float_error_pending_break_n_latch;
      hold_ff       <= nxt_hold;
      use_pin_ff    <= nxt_use_pin;
      float_error_pending_break_n_fsm_n_ff <= nxt_float_error_pending_break_n_fsm_n;
    end
  end

  // outputs straight from flops
  assign prdata                 = prdata_ff;
  assign pready                 = pready_ff;
  assign pslverr                = pslverr_ff;
  assign stop_clock_request_n   = stop_n_ff;
  assign stop_processor_clock_n = cpu_stop_n_ff;
  assign processor_sleep_n      = sleep_n_ff;
  assign deeper_sleep_n         = deeper_n_ff;
  assign deep_idle_status_n     = idle_stat_n_ff;
  assign regulator_low_voltage  = reg_low_ff;
  assign float_error_to_fsm_n   = float_error_pending_break_n_fsm_n_ff;

  // checks on the sequencer and throttle
  property p_level2_enter;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == pcst_pkg::ST_C0 && level_read && level_target == pcst_pkg::TGT_C2)
      |=> (!stop_clock_request_n && target_ff == pcst_pkg::TGT_C2);
  endproperty
  a_level2_enter: assert property (p_level2_enter) else $error("level2 read missed c2");

  property p_level3_target;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == pcst_pkg::ST_C0 && access_done && !pwrite && paddr == pcst_pkg::ADDR_LEVEL3)
      |=> (target_ff == ($past(deepest_on_level3_enable) ? pcst_pkg::TGT_C4 : pcst_pkg::TGT_C3));
  endproperty
  a_level3_target: assert property (p_level3_target) else $error("level3 target wrong");

  property p_c2_no_bm_break;
    @(posedge pclk) disable iff (!presetn)
    (state_ff == pcst_pkg::ST_GRANT && target_ff == pcst_pkg::TGT_C2 && !unmasked_irq &&
     !nmi_event && !smi_event && !init_event && !pbe_break) |=> (state_ff == pcst_pkg::ST_GRANT);
  endproperty
  a_c2_no_bm_break: assert property (p_c2_no_bm_break) else $error("c2 left without break");

  property p_no_throttle_idle;
    @(posedge pclk) disable iff (!presetn)
    (state_ff != pcst_pkg::ST_C0) |=> !thr_stop_ff;
  endproperty
  a_no_throttle_idle: assert property (p_no_throttle_idle) else $error("throttle in idle");

  property p_latch_stable;
    @(posedge pclk) disable iff (!presetn)
    (!stop_n_ff && $past(!stop_n_ff)) |-> $stable(float_error_pending_break_n_latch_ff);
  endproperty
  a_latch_stable: assert property (p_latch_stable) else $error("float error latch moved");

  property p_pin_wait;
    @(posedge pclk) disable iff (!presetn)
    ($rose(stop_n_ff)) |-> (!use_pin_ff ##1 !use_pin_ff ##1 use_pin_ff);
  endproperty
  a_pin_wait: assert property (p_pin_wait) else $error("float error hold wrong");

  property p_sleep_first;
    @(posedge pclk) disable iff (!presetn)
    $fell(cpu_stop_n_ff) |-> (!sleep_n_ff && $past(!sleep_n_ff));
  endproperty
  a_sleep_first: assert property (p_sleep_first) else $error("sleep not before cpu stop");

  property p_reg_low_c4;
    @(posedge pclk) disable iff (!presetn)
    reg_low_ff |-> (target_ff == pcst_pkg::TGT_C4 && state_ff == pcst_pkg::ST_DEEP);
  endproperty
  a_reg_low_c4: assert property (p_reg_low_c4) else $error("low voltage outside c4");

  property p_sleep_stops_throttle;
    @(posedge pclk) disable iff (!presetn)
    (sleep_enable && $past(sleep_enable)) |=> !thr_stop_ff;
  endproperty
  a_sleep_stops_throttle: assert property (p_sleep_stops_throttle) else $error("throttle in sleep");

endmodule : pcst_ctrl

`default_nettype wire

/* File: core/pcst_pkg.sv */
// pcst_pkg: register map, field positions, reset values, timing counts and
// state types for the processor idle-state and stop-clock throttle control.
// assumes a single 10 MHz pclk domain and a 32-bit apb slave with byte addresses.
package pcst_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LEVEL2 = 8'h04;
  localparam logic [7:0] ADDR_LEVEL3 = 8'h08;
  localparam logic [7:0] ADDR_LEVEL4 = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // control register layout
  localparam int          CTRL_WIDTH             = 12;
  localparam int          CTRL_THROTTLE_DUTY_LSB = 0;
  localparam int          CTRL_THROTTLE_ENABLE   = 3;
  localparam int          CTRL_THERMAL_DUTY_LSB  = 4;
  localparam int          CTRL_BUS_MASTER_RELOAD = 8;
  localparam int          CTRL_DEEPEST_ON_LEVEL3 = 9;
  localparam int          CTRL_PENDING_BREAK_MUX = 10;
  localparam int          CTRL_SLEEP_ENABLE      = 11;
  localparam int          DUTY_WIDTH             = 3;
  localparam logic [11:0] CTRL_RESET             = 12'h000;

  // status register layout
  localparam int STAT_CSTATE_LSB = 0;
  localparam int STAT_THROTTLING = 3;
  localparam int STAT_THERMAL_OV = 4;
  localparam int STAT_THERMAL_IN = 5;

  // reported c-state codes
  localparam logic [2:0] CSTATE_C0 = 3'h0;
  localparam logic [2:0] CSTATE_C1 = 3'h1;
  localparam logic [2:0] CSTATE_C2 = 3'h2;
  localparam logic [2:0] CSTATE_C3 = 3'h3;
  localparam logic [2:0] CSTATE_C4 = 3'h4;

  // timing
  localparam int CLK_PERIOD_NS        = 100;
  localparam int CLK_HZ               = 10_000_000;
  localparam int PBE_MIN_WAIT_NS      = 180;
  localparam int PBE_MAX_WAIT_NS      = 240;
  localparam int PBE_HOLD_CYC         = (PBE_MIN_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PBE_MAX_CYC          = PBE_MAX_WAIT_NS / CLK_PERIOD_NS;
  localparam int THERMAL_TIME_S       = 2;
  localparam int THERMAL_CYCLES       = THERMAL_TIME_S * CLK_HZ;
  localparam int THERMAL_CNT_WIDTH    = 25;
  localparam int THROTTLE_PERIOD_CLKS = 1024;
  localparam int THROTTLE_CNT_WIDTH   = $clog2(THROTTLE_PERIOD_CLKS);

  // idle sequencer states and idle targets
  typedef enum logic [2:0] {ST_C0, ST_GRANT, ST_SLEEP, ST_DEEP, ST_EXIT} pcst_state_t;
  typedef enum logic [1:0] {TGT_C2, TGT_C3, TGT_C4} pcst_target_t;

endpackage : pcst_pkg

/* File: dv/pcst_cpu_model.sv */
// pcst_cpu_model: processor and host bridge as seen from the stop-clock pins.
// assumes one pclk domain; pend_irq and slow come from the bench.
`timescale 1ns/100ps
`default_nettype none
module pcst_cpu_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // bench controls
  input  wire logic pend_irq,
  input  wire logic slow,
  // device side
  input  wire logic stop_clock_request_n,
  output logic      stop_grant,
  output logic      float_error_pending_break_n
);
  logic [3:0] cnt_ff;
  // grant after completion
  // one grant per stop assertion, late enough that the cycle has completed
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_ff <= 4'h0;
    else
      cnt_ff <= stop_clock_request_n ? 4'h0 : cnt_ff + {3'h0, cnt_ff != 4'hF};
  assign stop_grant = (cnt_ff == (slow ? 4'h9 : 4'h2));
  // pending break pin
  // low only under stop-clock; native high level returns at once on release
  assign float_error_pending_break_n = !(pend_irq && !stop_clock_request_n);
endmodule : pcst_cpu_model
`default_nettype wire

/* File: dv/processor_cstate_throttle_control_tb.sv */
// processor_cstate_throttle_control_tb: self-checking bench for idle states and throttling.
// assumes pcst_pkg, pcst_ctrl and pcst_cpu_model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module processor_cstate_throttle_control_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h2DBE;
  logic pready, pslverr, err, stop_grant, float_error_pending_break_n, float_error_to_fsm_n;
  logic stop_clock_request_n, stop_processor_clock_n, processor_sleep_n, deeper_sleep_n;
  logic deep_idle_status_n, regulator_low_voltage;
  logic [4:0] ev = 5'h00; // irq, nmi, smi, init, bus master
  logic in_c1 = 1'b0, thermal_alarm_n_n = 1'b1, pend = 1'b0, slow = 1'b0;
  logic [2:0] m_cs; // model c-state
  logic [7:0] ad [6] = '{8'h04, 8'h04, 8'h08, 8'h0C, 8'h08, 8'h0C};
  int evb [6] = '{4, 0, 4, 1, 2, 3};
  int fail_count = 0, n_checks = 0, cyc = 0, lo, i;

  // short override count keeps the thermal case inside the run budget
  pcst_ctrl #(.THERMAL_OVERRIDE_CYCLES(50)) u_pcst_ctrl (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .unmasked_irq(ev[0]), .nmi_event(ev[1]), .smi_event(ev[2]), .init_event(ev[3]),
    .bus_master_req(ev[4]), .stop_grant, .processor_in_c1(in_c1),
    .float_error_pending_break_n, .thermal_alarm_n(thermal_alarm_n_n), .stop_clock_request_n,
    .stop_processor_clock_n, .processor_sleep_n, .deeper_sleep_n, .deep_idle_status_n,
    .regulator_low_voltage, .float_error_to_fsm_n);
  pcst_cpu_model u_pcst_cpu_model (.pclk, .presetn, .pend_irq(pend), .slow,
    .stop_clock_request_n, .stop_grant, .float_error_pending_break_n);

  always #(pcst_pkg::CLK_PERIOD_NS / 2) pclk = ~pclk;

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  task results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; waits for pready however long the slave takes
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task stat(input logic [2:0] cs);
    apb(1'b0, pcst_pkg::ADDR_STATUS, 32'h0);
    chk(rd[2:0], cs);
  endtask : stat

  // settle past one throttle period, then count stopped cycles over one period
  task meas(input logic [31:0] exp);
    repeat (1100) @(posedge pclk);
    lo = 0;
    repeat (1024)
    begin
      @(posedge pclk);
      lo += (stop_clock_request_n === 1'b0);
    end
    chk(lo, exp);
  endtask : meas

  task pulse_irq();
    ev <= 5'h01;
    repeat (4) @(posedge pclk);
    ev <= 5'h00;
  endtask : pulse_irq

  // hang guard, about three times the expected run
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      results();
    end
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk({stop_clock_request_n, processor_sleep_n, stop_processor_clock_n,
      deep_idle_status_n, regulator_low_voltage, float_error_to_fsm_n}, 32'h3D);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    for (i = 0; i < 6; i++)
    begin
      lfsr = nxt(lfsr);
      slow <= lfsr[0];
      apb(1'b1, pcst_pkg::ADDR_CTRL, (i == 4) ? 32'h300 : 32'h100);
      m_cs = (ad[i] == 8'h04) ? 3'h2 : ((ad[i] == 8'h0C || i == 4) ? 3'h4 : 3'h3);
      apb(1'b0, ad[i], 32'h0);
      repeat (20) @(posedge pclk);
      stat(m_cs);
      chk({stop_clock_request_n, processor_sleep_n, stop_processor_clock_n, deeper_sleep_n,
        deep_idle_status_n, regulator_low_voltage},
        {1'b0, {4{m_cs == 3'h2}}, m_cs == 3'h4});
      ev[evb[i]] <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(stop_clock_request_n, !(evb[i] == 4 && m_cs == 3'h2));
      pulse_irq();
      stat(3'h0);
    end
    // pin latched while stopped; wakes only once the mux is on
    pend <= 1'b1;
    apb(1'b1, pcst_pkg::ADDR_CTRL, 32'h0);
    apb(1'b0, pcst_pkg::ADDR_LEVEL2, 32'h0);
    repeat (20) @(posedge pclk);
    chk({float_error_to_fsm_n, stop_clock_request_n}, 2'b10);
    apb(1'b1, pcst_pkg::ADDR_CTRL, 32'h400);
    repeat (10) @(posedge pclk);
    apb(1'b0, pcst_pkg::ADDR_STATUS, 32'h0);
    chk(rd[5:0], 6'h00);
    pend <= 1'b0;
    // manual duty, then thermal override over it, then sleep
    lfsr = nxt(lfsr);
    apb(1'b1, pcst_pkg::ADDR_CTRL, {28'h0, 1'b1, lfsr[2:0]});
    meas(128 * lfsr[2:0]);
    thermal_alarm_n_n <= 1'b0;
    apb(1'b1, pcst_pkg::ADDR_CTRL, {25'h0, lfsr[5:3], 4'h0});
    meas(128 * lfsr[5:3]);
    apb(1'b1, pcst_pkg::ADDR_CTRL, {25'h0, lfsr[5:3], 1'b1, ~lfsr[2:0]});
    meas(128 * lfsr[5:3]);
    apb(1'b1, pcst_pkg::ADDR_CTRL, {24'h008, 1'b0, lfsr[5:3], 4'h0});
    meas(0);
    thermal_alarm_n_n <= 1'b1;
    in_c1 <= 1'b1;
    apb(1'b1, pcst_pkg::ADDR_CTRL, 32'h00F);
    meas(896);
    apb(1'b0, pcst_pkg::ADDR_LEVEL2, 32'h0);
    repeat (20) @(posedge pclk);
    stat(3'h2);
    pulse_irq();
    meas(896);
    apb(1'b1, pcst_pkg::ADDR_CTRL, 32'h0);
    repeat (10) @(posedge pclk);
    stat(3'h1);
    results();
  end
endmodule : processor_cstate_throttle_control_tb
`default_nettype wire
